/* design/rlio_pkg.sv */
package rlio_pkg;

  // ==========================================================
  // Variants and widths
  typedef enum {RLIO_IN2, RLIO_OUT2, RLIO_MIXED, RLIO_QUAD} rlio_variant_e;
  localparam int TMR_W  = 21;
  localparam int ADDR_W = 8;

  // ==========================================================
  // Timing at the 50 MHz bus clock
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_KHZ        = CLK_HZ / 1000;
  localparam int T_START_US     = 10000;
  localparam int T_LOSS_STD_US  = 31000;
  localparam int T_LOSS_FAST_US = 5000;
  localparam int T_PER_STD_US   = 19200;
  localparam int T_PER_FAST_US  = 3000;
  localparam int START_CYC_DEF  = T_START_US * CLK_KHZ / 1000;
  localparam int LOSS_STD_DEF   = T_LOSS_STD_US * CLK_KHZ / 1000;
  localparam int LOSS_FAST_DEF  = T_LOSS_FAST_US * CLK_KHZ / 1000;
  localparam int PER_STD_DEF    = T_PER_STD_US * CLK_KHZ / 1000;
  localparam int PER_FAST_DEF   = T_PER_FAST_US * CLK_KHZ / 1000;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OUT0 = 8'h08;
  localparam logic [ADDR_W-1:0] REG_OUT1 = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IN0  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IN1  = 8'h14;

  // ==========================================================
  // Values
  localparam logic [7:0]  BASE_WORD   = 8'h1e;
  localparam logic [3:0]  UNIT_MAX    = 4'h9;
  localparam logic [1:0]  EN_RST_TWO  = 2'h3;
  localparam logic [1:0]  EN_RST_NONE = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] WORD_RST    = 16'h0000;

endpackage : rlio_pkg

/* design/rlio_chan_if.sv */
`timescale 1ns/10ps
interface rlio_chan_if;
  logic        fast;
  logic        clear_on_err;
  logic        flag_mode;
  logic        frame_valid;
  logic [15:0] frame_data;
  logic        frame_fast;
  logic [15:0] word;
  logic        err;

  modport chan (input fast, clear_on_err, flag_mode, frame_valid,
                input frame_data, frame_fast, output word, err);
  modport ctrl (output fast, clear_on_err, flag_mode, frame_valid,
                output frame_data, frame_fast, input word, err);
endinterface : rlio_chan_if

/* design/rlio_rx_chan.sv */
`timescale 1ns/10ps
module rlio_rx_chan
  import rlio_pkg::*;
#(
  parameter int START_CYC     = START_CYC_DEF,
  parameter int LOSS_STD_CYC  = LOSS_STD_DEF,
  parameter int LOSS_FAST_CYC = LOSS_FAST_DEF
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel bundle
  rlio_chan_if.chan ch
);

  // ==========================================================
  // Link state
  typedef enum {RX_WAIT_FIRST, RX_LINKED, RX_FAULT} rlio_rx_state_e;

  rlio_rx_state_e   state;
  rlio_rx_state_e   next_state;
  logic [TMR_W-1:0] timer;
  logic [15:0]      held;
  logic             err;

  wire good = ch.frame_valid && (ch.frame_fast == ch.fast);
  wire bad  = ch.frame_valid && !good;
  wire [TMR_W-1:0] loss_lim = ch.fast ? TMR_W'(LOSS_FAST_CYC - 1)
                                      : TMR_W'(LOSS_STD_CYC - 1);
  wire [TMR_W-1:0] limit = (state == RX_WAIT_FIRST)
                           ? TMR_W'(START_CYC - 1) : loss_lim;
  wire timeout = (timer == limit) && !ch.frame_valid;
  wire set_err = bad || timeout;

  always_comb
  begin
    next_state = state;
    unique case (state)
      RX_WAIT_FIRST: if (good) next_state = RX_LINKED;
      RX_LINKED:     if (set_err) next_state = RX_FAULT;
      RX_FAULT:      if (good) next_state = RX_LINKED;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= RX_WAIT_FIRST;
      timer <= '0;
    end
    else
    begin
      state <= next_state;
      if (good)
        timer <= '0;
      else if (timer != limit)
        timer <= timer + 1'b1;
    end
  end

  // Flag starts clear, set on timeout or bad frame, cleared by a good one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      err <= 1'b0;
    else if (good)
      err <= 1'b0;
    else if (set_err)
      err <= 1'b1;
  end

  // Inputs stay zero until the first good frame, then hold or clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      held <= WORD_RST;
    else if (good)
      held <= ch.frame_data;
    else if (set_err && ch.clear_on_err)
      held <= WORD_RST;
  end

  assign ch.word = {ch.flag_mode ? err : held[15], held[14:0]};
  assign ch.err  = err;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence quiet_start;
    state == RX_WAIT_FIRST && timer == limit && !ch.frame_valid;
  endsequence

  start_zero_a:
    assert property (state == RX_WAIT_FIRST |-> ch.word[14:0] == 15'h0000)
    else $error("Input bits set before first good frame");
  start_time_a:
    assert property (quiet_start |=> err)
    else $error("Start timeout did not raise the error");
  mismatch_a:
    assert property (bad |=> err && state != RX_LINKED)
    else $error("Frame of wrong timing not reported");
  clear_hold_a:
    assert property (state == RX_LINKED && bad |=> ch.word[14:0] ==
      ($past(ch.clear_on_err) ? 15'h0000 : $past(held[14:0])))
    else $error("Wrong hold or clear action on error");
  flag_set_a:
    assert property (ch.flag_mode && set_err |=> ch.word[15])
    else $error("Bit 15 not set on error in flag mode");
  recover_a:
    assert property (state == RX_FAULT && good |=> !ch.err &&
      held == $past(ch.frame_data))
    else $error("Recovery did not restore the input word");

endmodule : rlio_rx_chan

/* design/rlio_link.sv */
`timescale 1ns/10ps
module rlio_link
  import rlio_pkg::*;
#(
  parameter rlio_variant_e VARIANT = RLIO_QUAD,
  parameter int START_CYC     = START_CYC_DEF,
  parameter int LOSS_STD_CYC  = LOSS_STD_DEF,
  parameter int LOSS_FAST_CYC = LOSS_FAST_DEF,
  parameter int PER_STD_CYC   = PER_STD_DEF,
  parameter int PER_FAST_CYC  = PER_FAST_DEF
)(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Front switches
  input  wire logic [3:0]        unit_number_sel,
  input  wire logic              delay_sel,
  input  wire logic              error_process_sel,
  input  wire logic              input_mode_sel,
  input  wire logic              lamp_one_enable_sel,
  input  wire logic              lamp_two_enable_sel,
  // Receive lines
  input  wire logic              receive_line_one_valid,
  input  wire logic [15:0]       receive_line_one_data,
  input  wire logic              receive_line_one_fast,
  input  wire logic              receive_line_two_valid,
  input  wire logic [15:0]       receive_line_two_data,
  input  wire logic              receive_line_two_fast,
  // Transmit lines
  output logic                   transmit_line_one_valid,
  output logic [15:0]            transmit_line_one_data,
  output logic                   transmit_line_one_fast,
  output logic                   transmit_line_two_valid,
  output logic [15:0]            transmit_line_two_data,
  output logic                   transmit_line_two_fast,
  // Lamps
  output logic                   fast_delay_lamp,
  output logic                   reset_on_error_lamp,
  output logic                   error_flag_mode_lamp,
  output logic                   error_lamp_one,
  output logic                   error_lamp_two
);

  // ==========================================================
  // Variant shape
  localparam int NUM_IN  = (VARIANT == RLIO_OUT2) ? 0 :
                           (VARIANT == RLIO_MIXED) ? 1 : 2;
  localparam int NUM_OUT = (VARIANT == RLIO_IN2) ? 0 :
                           (VARIANT == RLIO_MIXED) ? 1 : 2;
  localparam logic [1:0] EN_RST = (NUM_IN == 2) ? EN_RST_TWO
                                                : EN_RST_NONE;

  // ==========================================================
  // Settings captured once after reset release
  logic       cfg_taken;
  logic [3:0] cfg_unit;
  logic       cfg_fast;
  logic       cfg_clear;
  logic       cfg_flag;
  logic [1:0] cfg_en;
  logic [7:0] base_word;
  logic       unit_bad;

  wire       next_clear = error_process_sel && (NUM_IN != 0);
  wire       next_flag  = input_mode_sel && (NUM_IN != 0);
  wire [1:0] next_en    = {lamp_two_enable_sel && (NUM_IN == 2),
                           lamp_one_enable_sel && (NUM_IN != 0)};
  wire [7:0] next_base  = BASE_WORD + {3'h0, unit_number_sel, 1'b0};
  wire       next_bad   = (unit_number_sel > UNIT_MAX) ||
                          (VARIANT == RLIO_QUAD &&
                           unit_number_sel == UNIT_MAX);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_taken <= 1'b0;
      cfg_unit  <= 4'h0;
      cfg_fast  <= 1'b0;
      cfg_clear <= 1'b0;
      cfg_flag  <= 1'b0;
      cfg_en    <= EN_RST;
      base_word <= BASE_WORD;
      unit_bad  <= 1'b0;
    end
    else if (!cfg_taken)
    begin
      cfg_taken <= 1'b1;
      cfg_unit  <= unit_number_sel;
      cfg_fast  <= delay_sel;
      cfg_clear <= next_clear;
      cfg_flag  <= next_flag;
      cfg_en    <= next_en;
      base_word <= next_base;
      unit_bad  <= next_bad;
    end
  end

  // Outputs occupy the first words, inputs follow
  wire [7:0] in_base = base_word + 8'(NUM_OUT);

  // ==========================================================
  // Input channels
  rlio_chan_if chif [2] ();

  wire [1:0]  rx_valid = {receive_line_two_valid, receive_line_one_valid};
  wire [1:0]  rx_fast  = {receive_line_two_fast, receive_line_one_fast};
  wire [15:0] rx_data [2];
  logic [15:0] in_word [2];
  logic [1:0]  in_err;

  assign rx_data[0] = receive_line_one_data;
  assign rx_data[1] = receive_line_two_data;

  for (genvar gi = 0; gi < 2; gi++)
  begin : g_rx
    assign chif[gi].fast         = cfg_fast;
    assign chif[gi].clear_on_err = cfg_clear;
    assign chif[gi].flag_mode    = cfg_flag;
    assign chif[gi].frame_valid  = rx_valid[gi] && (gi < NUM_IN);
    assign chif[gi].frame_data   = rx_data[gi];
    assign chif[gi].frame_fast   = rx_fast[gi];
    rlio_rx_chan #(
      .START_CYC     (START_CYC),
      .LOSS_STD_CYC  (LOSS_STD_CYC),
      .LOSS_FAST_CYC (LOSS_FAST_CYC)
    ) u_rx (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ch      (chif[gi])
    );
    assign in_word[gi] = (gi < NUM_IN) ? chif[gi].word : WORD_RST;
    assign in_err[gi]  = (gi < NUM_IN) && chif[gi].err;
  end

  // ==========================================================
  // Lamps
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fast_delay_lamp      <= 1'b0;
      reset_on_error_lamp  <= 1'b0;
      error_flag_mode_lamp <= 1'b0;
      error_lamp_one       <= 1'b0;
      error_lamp_two       <= 1'b0;
    end
    else
    begin
      fast_delay_lamp      <= cfg_fast;
      reset_on_error_lamp  <= cfg_clear;
      error_flag_mode_lamp <= cfg_flag;
      error_lamp_one       <= in_err[0] && cfg_en[0];
      error_lamp_two       <= in_err[1] && cfg_en[1];
    end
  end

  // ==========================================================
  // Output words and periodic transmission
  logic [15:0]      out_word [2];
  logic [TMR_W-1:0] tx_cnt;

  wire [TMR_W-1:0] tx_lim = cfg_fast ? TMR_W'(PER_FAST_CYC - 1)
                                     : TMR_W'(PER_STD_CYC - 1);
  wire tx_tick = (tx_cnt == tx_lim);
  wire tx_on   = tx_tick && cfg_taken && !unit_bad;

  // Send-only: nothing comes back from the output terminals
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_cnt                  <= '0;
      transmit_line_one_valid <= 1'b0;
      transmit_line_one_data  <= WORD_RST;
      transmit_line_one_fast  <= 1'b0;
      transmit_line_two_valid <= 1'b0;
      transmit_line_two_data  <= WORD_RST;
      transmit_line_two_fast  <= 1'b0;
    end
    else
    begin
      tx_cnt                  <= tx_tick ? '0 : tx_cnt + 1'b1;
      transmit_line_one_valid <= tx_on && (NUM_OUT > 0);
      transmit_line_one_data  <= out_word[0];
      transmit_line_one_fast  <= cfg_fast;
      transmit_line_two_valid <= tx_on && (NUM_OUT > 1);
      transmit_line_two_data  <= out_word[1];
      transmit_line_two_fast  <= cfg_fast;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_have;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_have;

  wire aw_hs    = s_axi_awvalid && s_axi_awready;
  wire w_hs     = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire [1:0] wr_sel = {aw_addr == REG_OUT1, aw_addr == REG_OUT0};
  wire wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= REG_IN1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (aw_hs)
    begin
      aw_have <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      if (do_write)
        aw_have <= 1'b0;
      s_axi_awready <= !aw_have && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end
    else if (w_hs)
    begin
      w_have <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (do_write)
        w_have <= 1'b0;
      s_axi_wready <= !w_have && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  for (genvar gw = 0; gw < 2; gw++)
  begin : g_out
    wire [15:0] merged = {w_strb[1] ? w_data[15:8] : out_word[gw][15:8],
                          w_strb[0] ? w_data[7:0] : out_word[gw][7:0]};
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        out_word[gw] <= WORD_RST;
      else if (do_write && wr_sel[gw])
        out_word[gw] <= merged;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire [31:0] rd_cfg  = {20'h0, cfg_unit, 3'h0, cfg_en, cfg_flag,
                         cfg_clear, cfg_fast};
  wire [31:0] rd_stat = {8'h00, in_base, base_word, 3'h0, unit_bad,
                         cfg_taken, 1'b0, in_err};
  wire rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= REG_IN1);
  wire [31:0] rd_data =
    (s_axi_araddr == REG_CFG)  ? rd_cfg :
    (s_axi_araddr == REG_STAT) ? rd_stat :
    (s_axi_araddr == REG_OUT0) ? {16'h0000, out_word[0]} :
    (s_axi_araddr == REG_OUT1) ? {16'h0000, out_word[1]} :
    (s_axi_araddr == REG_IN0)  ? {16'h0000, in_word[0]} :
    (s_axi_araddr == REG_IN1)  ? {16'h0000, in_word[1]} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence both_held;
    aw_have && w_have && !s_axi_bvalid;
  endsequence

  cfg_hold_a:
    assert property (cfg_taken |=> $stable(cfg_unit) && $stable(cfg_fast)
      && $stable(cfg_clear) && $stable(cfg_flag) && $stable(cfg_en))
    else $error("Settings changed after capture");
  base_word_a:
    assert property (cfg_taken |-> base_word ==
      BASE_WORD + {3'h0, cfg_unit, 1'b0})
    else $error("First word does not match unit number");
  quad_nine_a:
    assert property (cfg_taken && VARIANT == RLIO_QUAD &&
      cfg_unit == UNIT_MAX |=> !transmit_line_one_valid && unit_bad)
    else $error("Four-word unit accepted number nine");
  fast_lamp_a:
    assert property (cfg_taken |=> fast_delay_lamp == cfg_fast)
    else $error("Fast-delay lamp disagrees with setting");
  lamp_gate_a:
    assert property (cfg_taken && !cfg_en[0] |=> !error_lamp_one)
    else $error("Error lamp lit while disabled");
  lamp_two_a:
    assert property (in_err[1] && cfg_en[1] |=> error_lamp_two)
    else $error("Second lamp missed second word error");
  out_only_a:
    assert property (VARIANT == RLIO_OUT2 |-> !cfg_clear && !cfg_flag
      && cfg_en == 2'h0)
    else $error("Output-only unit uses unused setting");
  defaults_a:
    assert property (!cfg_taken |-> cfg_en == EN_RST && !cfg_fast)
    else $error("Wrong setting defaults before capture");
  write_resp_a:
    assert property (both_held |=> s_axi_bvalid && !aw_have && !w_have)
    else $error("Write response not raised");

endmodule : rlio_link

/* dv/rlio_term_model.sv */
`timescale 1ns/10ps
// Remote input terminal: one frame per send pulse
module rlio_term_model (
  // Clock
  input  wire logic        aclk,
  // Stimulus
  input  wire logic        send,
  input  wire logic [15:0] send_data,
  input  wire logic        send_fast,
  // Line
  output logic             valid,
  output logic [15:0]      data,
  output logic             fast
);
  initial
  begin
    valid = 1'b0;
    data  = 16'h0000;
    fast  = 1'b0;
  end
  // Idle lines show the inverse of the last value; no error path back
  always @(posedge aclk)
  begin
    valid <= send;
    data  <= send ? send_data : ~data;
    fast  <= send ? send_fast : ~fast;
  end
endmodule : rlio_term_model

/* dv/remote_io_link_interface_tb.sv */
`timescale 1ns/10ps
module remote_io_link_interface_tb;
  import rlio_pkg::*;
  // ==========================================================
  // Signals
  logic        aclk, aresetn, awv, wv, bready, arv, rready, awr, wr, arr;
  logic        bv, rv, dsel, esel, msel, en1, en2, s1, s2, f1, f2, tv2;
  logic        rv1, rv2, rf1, rf2, tv1, tf1, tf2, lf, lc, lm, le1, le2;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  unit, ws;
  logic [7:0]  awa, ara;
  logic [15:0] d1, d2, rd1, rd2, td1, td2, x;
  logic [31:0] wd, rdata, v, n;
  int          err_count = 0;
  int          total_checks = 0;

  rlio_link #(.START_CYC(50), .LOSS_STD_CYC(80),
    .LOSS_FAST_CYC(40), .PER_STD_CYC(60), .PER_FAST_CYC(30)) i_rlio_link (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .unit_number_sel(unit), .delay_sel(dsel),
    .error_process_sel(esel), .input_mode_sel(msel),
    .lamp_one_enable_sel(en1), .lamp_two_enable_sel(en2),
    .receive_line_one_valid(rv1), .receive_line_one_data(rd1),
    .receive_line_one_fast(rf1), .receive_line_two_valid(rv2),
    .receive_line_two_data(rd2), .receive_line_two_fast(rf2),
    .transmit_line_one_valid(tv1), .transmit_line_one_data(td1),
    .transmit_line_one_fast(tf1), .transmit_line_two_valid(tv2),
    .transmit_line_two_data(td2), .transmit_line_two_fast(tf2),
    .fast_delay_lamp(lf), .reset_on_error_lamp(lc),
    .error_flag_mode_lamp(lm), .error_lamp_one(le1),
    .error_lamp_two(le2));
  rlio_term_model i_term_one (.aclk(aclk), .send(s1), .send_data(d1),
    .send_fast(f1), .valid(rv1), .data(rd1), .fast(rf1));
  rlio_term_model i_term_two (.aclk(aclk), .send(s2), .send_data(d2),
    .send_fast(f2), .valid(rv2), .data(rd2), .fast(rf2));

  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Expected input word: bit 15 is the flag in flag mode
  function automatic logic [31:0] in_exp(input logic [15:0] d,
                                         input logic fl, input logic e);
    return {16'h0000, fl ? e : d[15], d[14:0]};
  endfunction : in_exp

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic wrt(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] rs);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wr === 1'b1) wv <= 1'b0;
    end
    while (awv || wv);
    while (bv !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wrt

  // One frame on line one (ln low) or line two (ln high)
  task automatic frame(input logic ln, input logic [15:0] d,
                       input logic f);
    {d2, d1} <= {d, d};
    {f2, f1} <= {f, f};
    {s2, s1} <= {ln, !ln};
    @(posedge aclk);
    {s2, s1} <= 2'b00;
    repeat (3) @(posedge aclk);
  endtask : frame

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // ==========================================================
  // Clock, watchdog, tests
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial
  begin
    #200000;
    err_count++;
    results();
  end

  initial
  begin
    void'($urandom(32'hbb290272));
    {aresetn, awv, wv, bready, arv, rready, s1, s2, f1, f2} = '0;
    {awa, ara, wd, d1, d2, ws} = '0;
    {unit, dsel, esel, msel, en1, en2} = {4'h2, 5'b11110};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    unit <= 4'h5;
    dsel <= 1'b0;
    rd(REG_CFG, v, r);
    chk("cfg", 32'h0000020f, v);
    rd(REG_STAT, v, r);
    chk("first word", 32'd34, v[15:8]);
    chk("input word", 32'h24, v[23:16]);
    chk("lamps", 5'b11100, {lf, lc, lm, le1, le2});
    rd(REG_IN0, v, r);
    chk("in0 start", 32'h0, v);
    $display("test config done");
    repeat (60) @(posedge aclk);
    rd(REG_IN0, v, r);
    chk("in0 start flag", 32'h8000, v);
    rd(REG_STAT, v, r);
    chk("err bits", 32'h3, v[1:0]);
    chk("err lamps", 2'b10, {le1, le2});
    $display("test start done");
    for (int i = 0; i < 4; i++)
    begin
      x = 16'($urandom);
      frame(1'b0, x, 1'b1);
      rd(REG_IN0, v, r);
      chk("in0 good", {17'h0, x[14:0]}, v);
      chk("lamp one good", 1'b0, le1);
    end
    frame(1'b0, 16'($urandom), 1'b0);
    rd(REG_IN0, v, r);
    chk("in0 wrong timing", 32'h8000, v);
    chk("lamp one err", 1'b1, le1);
    x = 16'($urandom);
    frame(1'b0, x, 1'b1);
    rd(REG_IN0, v, r);
    chk("in0 recover", in_exp(x, 1'b1, 1'b0), v);
    $display("test receive done");
    x = 16'($urandom);
    wrt(REG_OUT0, {16'h0, x}, 4'hf, r);
    chk("bresp out0", RESP_OKAY, r);
    wrt(REG_OUT1, {16'h0, ~x}, 4'h1, r);
    chk("bresp out1", RESP_OKAY, r);
    do @(posedge aclk); while (tv1 !== 1'b1);
    chk("tx one data", x, td1);
    chk("tx two", {1'b1, 8'h00, ~x[7:0]}, {tv2, td2});
    chk("tx one fast", 1'b1, tf1);
    rd(8'h18, v, r);
    chk("rresp unmapped", RESP_SLVERR, r);
    wrt(8'h02, 32'h0, 4'hf, r);
    chk("bresp unaligned", RESP_SLVERR, r);
    $display("test transmit done");
    aresetn <= 1'b0;
    {unit, dsel, esel, msel, en1, en2} <= {4'h9, 5'b00001};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    x = 16'($urandom);
    frame(1'b1, x, 1'b0);
    rd(REG_IN1, v, r);
    chk("in1 good", in_exp(x, 1'b0, 1'b0), v);
    frame(1'b1, ~x, 1'b1);
    rd(REG_IN1, v, r);
    chk("in1 hold", in_exp(x, 1'b0, 1'b1), v);
    chk("lamp two err", 1'b1, le2);
    repeat (40) @(posedge aclk);
    rd(REG_IN0, v, r);
    chk("in0 no flag", 32'h0, v);
    rd(REG_STAT, v, r);
    chk("stat nine", {8'h32, 8'h30, 8'h1b}, v[23:0]);
    chk("lamps nine", 5'b00001, {lf, lc, lm, le1, le2});
    n = '0;
    repeat (70) @(posedge aclk) n = n + tv1;
    chk("tx at nine", 32'h0, n);
    $display("test reset done");
    results();
  end
endmodule : remote_io_link_interface_tb
